// ==== hdl/cmc_top.sv ====
// Charge mode control: fast/trickle decision with AHB-Lite status registers
// Notes on behaviour
// - Fast charge selected right after power-up, before any condition acts.
// - Trickle shown by driving the rate output low; full charge latches it.
// - All three programming inputs low selects temperature mode, timer off.
// - Time mode decodes low_ref,sense,high_ref into 283..71 minute limit.
// - In temperature mode, under temperature forces trickle only while present, no latch.
// - In temperature mode, over temperature sets a latch that keeps trickle after cooling.
// - Over temperature latch cleared by window entry or supply recovery pulse, and held clear during lockout.
// - Window entry pulses reset to timer and latches; fast follows if backup, sense and supply allow.
// - Sense outside window holds trickle.
// - After holdoff, two consecutive slope events in window latch trickle.
// - Timer past selected limit latches trickle until a reset pulse.
// - Fast only when backup, sense and supply are all within range.
// - Undervoltage lockout holds trickle and keeps timer and latch reset.
// - Sense below lower threshold resets slope detection each time.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cmc_top #(
  parameter int SEC_CYCLES = cmc_pkg::CMC_SEC_CYCLES,
  parameter int HOLDOFF_S  = cmc_pkg::CMC_HOLDOFF_S
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire cmc_pkg::cmc_comp_t comp_raw,
  output logic                   fast_mode,
  output logic                   irq
);

  cmc_pkg::cmc_comp_t comp;

  cmc_sync #(
    .W ($bits(cmc_pkg::cmc_comp_t))
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (comp_raw),
    .q       (comp)
  );

  // Decode of window, mode and reset pulses
  logic in_window;
  logic in_window_d;
  logic uvlo_d;
  logic slope_d;
  logic reset_pulse;
  logic temp_mode;
  logic [2:0] prog_code;
  logic [8:0] limit_min;

  assign in_window   = !comp.sense_low && !comp.sense_high;
  assign temp_mode   = !(comp.prog_low_ref || comp.prog_sense || comp.prog_high_ref);
  assign prog_code   = {comp.prog_low_ref, comp.prog_sense, comp.prog_high_ref};
  // Pulse on window entry or supply recovery, one cycle wide
  assign reset_pulse = (in_window && !in_window_d) || (!comp.uvlo && uvlo_d);

  always_comb
  begin
    unique case (prog_code)
      3'b111:  limit_min = cmc_pkg::CMC_LIM_111;
      3'b110:  limit_min = cmc_pkg::CMC_LIM_110;
      3'b101:  limit_min = cmc_pkg::CMC_LIM_101;
      3'b100:  limit_min = cmc_pkg::CMC_LIM_100;
      3'b011:  limit_min = cmc_pkg::CMC_LIM_011;
      3'b010:  limit_min = cmc_pkg::CMC_LIM_010;
      3'b001:  limit_min = cmc_pkg::CMC_LIM_001;
      default: limit_min = 9'h1FF; // Temperature mode, never reached
    endcase
  end

  // Reset state treats window and supply as good, so power-up stays fast
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_window_d <= 1'b1;
      uvlo_d      <= 1'b0;
      slope_d     <= 1'b0;
    end
    else
    begin
      in_window_d <= in_window;
      uvlo_d      <= comp.uvlo;
      slope_d     <= comp.neg_slope;
    end
  end

  // Timebase: seconds prescaler, minute count, holdoff count
  logic [31:0] pre_cnt;
  logic        sec_tick;
  logic [5:0]  sec_in_min;
  logic [8:0]  minutes;
  logic [15:0] fast_secs;
  logic        timer_clr;
  logic        holdoff_done;
  logic        ctrl_slope_en;

  assign sec_tick     = (pre_cnt == 32'(SEC_CYCLES - 1));
  assign timer_clr    = reset_pulse || comp.uvlo;
  assign holdoff_done = (fast_secs >= 16'(HOLDOFF_S));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_cnt <= 32'h0000_0000;
    else if (sec_tick)
      pre_cnt <= 32'h0000_0000;
    else
      pre_cnt <= pre_cnt + 32'h0000_0001;
  end

  // Backup timer counts fast-charge minutes in time mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sec_in_min <= 6'h00;
      minutes    <= 9'h000;
    end
    else if (timer_clr || temp_mode)
    begin
      sec_in_min <= 6'h00;
      minutes    <= 9'h000;
    end
    else if (sec_tick && fast_mode && minutes != 9'h1FF)
    begin
      if (sec_in_min == 6'(cmc_pkg::CMC_MINUTE_S - 1))
      begin
        sec_in_min <= 6'h00;
        minutes    <= minutes + 9'h001;
      end
      else
        sec_in_min <= sec_in_min + 6'h01;
    end
  end

  // Holdoff seconds spent in fast mode; saturates
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fast_secs <= 16'h0000;
    else if (reset_pulse || comp.uvlo)
      fast_secs <= 16'h0000;
    else if (sec_tick && fast_mode && !holdoff_done)
      fast_secs <= fast_secs + 16'h0001;
  end

  // Trickle latches and slope detector
  logic       ot_latch;
  logic       full_latch;
  logic       time_latch;
  logic [1:0] slope_cnt;
  logic       slope_ev;

  assign slope_ev = comp.neg_slope && !slope_d && in_window && ctrl_slope_en;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slope_cnt <= 2'h0;
    else if (comp.sense_low || reset_pulse)
      slope_cnt <= 2'h0;
    else if (slope_ev && slope_cnt != 2'h2)
      slope_cnt <= slope_cnt + 2'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ot_latch   <= 1'b0;
      full_latch <= 1'b0;
      time_latch <= 1'b0;
    end
    else
    begin
      // Lockout holds the latch in reset; a pulse clears it
      if (comp.uvlo || reset_pulse)
        ot_latch <= 1'b0;
      else if (temp_mode && comp.over_temp)
        ot_latch <= 1'b1;
      if (reset_pulse)
        full_latch <= 1'b0;
      else if (slope_cnt == 2'h2 && holdoff_done && in_window)
        full_latch <= 1'b1;
      if (timer_clr || temp_mode)
        time_latch <= 1'b0;
      else if (minutes > limit_min)
        time_latch <= 1'b1;
    end
  end

  logic next_fast;
  logic backup_ok;

  assign backup_ok = temp_mode ? (!comp.under_temp && !ot_latch && !comp.over_temp)
                               : !time_latch;
  assign next_fast = backup_ok && in_window && !comp.uvlo && !full_latch;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fast_mode <= 1'b1;
    else
      fast_mode <= next_fast;
  end

  // Interrupt events
  logic [cmc_pkg::CMC_EV_W-1:0] events;
  logic [cmc_pkg::CMC_EV_W-1:0] irq_stat;
  logic [cmc_pkg::CMC_EV_W-1:0] irq_mask;
  logic [cmc_pkg::CMC_EV_W-1:0] w1c;

  assign events[cmc_pkg::CMC_EV_TRICKLE]  = fast_mode && !next_fast;
  assign events[cmc_pkg::CMC_EV_FULL]     = slope_cnt == 2'h2 && holdoff_done && !full_latch
                                            && in_window && !reset_pulse;
  assign events[cmc_pkg::CMC_EV_OVERTEMP] = temp_mode && comp.over_temp && !ot_latch
                                            && !comp.uvlo && !reset_pulse;
  assign events[cmc_pkg::CMC_EV_TIMEOUT]  = !time_latch && !timer_clr && !temp_mode
                                            && minutes > limit_min;
  assign events[cmc_pkg::CMC_EV_RESETP]   = reset_pulse;
  assign irq = |(irq_stat & irq_mask);

  // AHB-Lite slave: zero wait, OKAY only
  logic        dp_write;
  logic        dp_read;
  logic [7:0]  dp_addr;
  logic        ap_valid;
  logic [31:0] ctrl;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign ap_valid  = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ctrl_slope_en = ctrl[cmc_pkg::CMC_CTRL_SLOPE_EN] == 1'b0;
  assign w1c = (dp_write && dp_addr == cmc_pkg::CMC_OFF_IRQ)
               ? hwdata[cmc_pkg::CMC_EV_W-1:0] : '0;
  assign status_word = {24'h000000, 2'h0, temp_mode, comp.uvlo, time_latch,
                        full_latch, ot_latch, fast_mode};

  always_comb
  begin
    unique case (dp_addr)
      cmc_pkg::CMC_OFF_CTRL:   rd_mux = ctrl;
      cmc_pkg::CMC_OFF_STATUS: rd_mux = status_word;
      cmc_pkg::CMC_OFF_IRQ:    rd_mux = {27'h0, irq_stat};
      cmc_pkg::CMC_OFF_MASK:   rd_mux = {27'h0, irq_mask};
      cmc_pkg::CMC_OFF_LIMIT:  rd_mux = {23'h0, limit_min};
      cmc_pkg::CMC_OFF_TIMER:  rd_mux = {23'h0, minutes};
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  assign hrdata = dp_read ? rd_mux : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else
    begin
      dp_write <= ap_valid && hwrite;
      dp_read  <= ap_valid && !hwrite;
      dp_addr  <= ap_valid ? haddr[7:0] : dp_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl     <= cmc_pkg::CMC_CTRL_RST;
      irq_mask <= '0;
      irq_stat <= '0;
    end
    else
    begin
      if (dp_write && dp_addr == cmc_pkg::CMC_OFF_CTRL)
        ctrl <= hwdata;
      if (dp_write && dp_addr == cmc_pkg::CMC_OFF_MASK)
        irq_mask <= hwdata[cmc_pkg::CMC_EV_W-1:0];
      // New events win over a same-cycle clear
      irq_stat <= (irq_stat & ~w1c) | events;
    end
  end

endmodule

// ==== hdl/cmc_pkg.sv ====
// Package with constants and carrier types for the charge mode control block
package cmc_pkg;

  // AHB-Lite register byte offsets
  localparam logic [7:0] CMC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CMC_OFF_STATUS = 8'h04;
  localparam logic [7:0] CMC_OFF_IRQ    = 8'h08;
  localparam logic [7:0] CMC_OFF_MASK   = 8'h0C;
  localparam logic [7:0] CMC_OFF_LIMIT  = 8'h10;
  localparam logic [7:0] CMC_OFF_TIMER  = 8'h14;

  // Control register reset value and field positions
  localparam logic [31:0] CMC_CTRL_RST     = 32'h0000_0000;
  localparam int          CMC_CTRL_SLOPE_EN = 0;

  // Interrupt event bit positions
  localparam int CMC_EV_TRICKLE  = 0;
  localparam int CMC_EV_FULL     = 1;
  localparam int CMC_EV_OVERTEMP = 2;
  localparam int CMC_EV_TIMEOUT  = 3;
  localparam int CMC_EV_RESETP   = 4;
  localparam int CMC_EV_W        = 5;

  // Nominal time figures
  localparam int CMC_CLK_HZ       = 25_000_000;
  localparam int CMC_HOLDOFF_S    = 160;
  localparam int CMC_MINUTE_S     = 60;
  // One-second prescaler count derived from the clock rate
  localparam int CMC_SEC_CYCLES   = CMC_CLK_HZ;

  // Time limits in minutes, index is {low_ref, sense, high_ref}
  localparam logic [8:0] CMC_LIM_111 = 9'd283;
  localparam logic [8:0] CMC_LIM_110 = 9'd247;
  localparam logic [8:0] CMC_LIM_101 = 9'd212;
  localparam logic [8:0] CMC_LIM_100 = 9'd177;
  localparam logic [8:0] CMC_LIM_011 = 9'd141;
  localparam logic [8:0] CMC_LIM_010 = 9'd106;
  localparam logic [8:0] CMC_LIM_001 = 9'd71;

  // Raw comparator results from the analog front end
  typedef struct packed {
    logic sense_low;     // sense below lower threshold
    logic sense_high;    // sense above upper threshold
    logic neg_slope;     // one less-than-peak sample event
    logic prog_low_ref;  // programming inputs, open reads 1
    logic prog_sense;
    logic prog_high_ref;
    logic under_temp;
    logic over_temp;
    logic uvlo;          // supply undervoltage lockout
  } cmc_comp_t;

endpackage

// ==== hdl/cmc_sync.sv ====
// Two-flop synchroniser bank for comparator levels
`timescale 1ns/1ps
module cmc_sync #(
  parameter int W = 9
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          meta[i] <= 1'b0;
          q[i]    <= 1'b0;
        end
        else
        begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// ==== bench/cmc_monitor.sv ====
// Port-level assertions for the charge mode control block
`timescale 1ns/1ps
module cmc_monitor (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic               hready,
  input  wire logic [31:0]        hrdata,
  input  wire logic               hreadyout,
  input  wire logic               hresp,
  input  wire cmc_pkg::cmc_comp_t comp_raw,
  input  wire logic               fast_mode
);
  logic [1:0] rst_cnt;
  logic       rd_dp;
  wire        tm = ~(comp_raw.prog_low_ref | comp_raw.prog_sense | comp_raw.prog_high_ref);
  wire        out_win = comp_raw.sense_low | comp_raw.sense_high;
  wire        good = ~out_win & ~comp_raw.uvlo & ~tm;
  // Saturating count of edges since reset release
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rst_cnt <= 2'h0;
      rd_dp   <= 1'b0;
    end
    else
    begin
      rst_cnt <= (rst_cnt == 2'h3) ? rst_cnt : rst_cnt + 2'h1;
      rd_dp   <= hsel & htrans[1] & hready & ~hwrite;
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_PWRUP: assert property (rst_cnt < 2'h2 |-> fast_mode) else $error("trickle at start");
  AST_OUT_WIN: assert property (out_win [*3] |=> !fast_mode) else $error("fast out of window");
  AST_UVLO: assert property (comp_raw.uvlo [*3] |=> !fast_mode) else $error("fast in lockout");
  AST_COLD: assert property ((tm && comp_raw.under_temp) [*3] |=> !fast_mode)
    else $error("fast when cold");
  AST_HOT: assert property ((tm && comp_raw.over_temp) [*3] |=> !fast_mode)
    else $error("fast when hot");
  // Entry pulse clears latches one edge before fast can rise
  AST_ENTRY: assert property (out_win && !comp_raw.uvlo ##1 good [*5] |-> fast_mode)
    else $error("no fast after entry");
  AST_IDLE_DATA: assert property (!rd_dp |-> hrdata == 32'h0) else $error("stray read data");
  AST_OKAY: assert property (hreadyout && !hresp) else $error("wait or error response");
  cover property (fast_mode ##1 !fast_mode);
  cover property (!fast_mode ##1 fast_mode);
  cover property (rd_dp);
endmodule

// ==== bench/cmc_pack_model.sv ====
// Battery pack, thermistor and supply model feeding comparator results
`timescale 1ns/1ps
module cmc_pack_model (
  input  wire logic [1:0]    sense_lvl,
  input  wire logic [2:0]    prog,
  input  wire logic [1:0]    temp_lvl,
  input  wire logic          slope,
  input  wire logic          supply_low,
  output cmc_pkg::cmc_comp_t comp_raw
);
  // Levels: 0 low or cold, 1 in range, 2 high or hot
  assign comp_raw = {sense_lvl == 2'h0, sense_lvl == 2'h2, slope, prog,
                     temp_lvl == 2'h0, temp_lvl == 2'h2, supply_low};
endmodule

// ==== bench/test_charge_mode_control.sv ====
// Self-checking testbench for the charge mode control block
`timescale 1ns/1ps
module test_charge_mode_control;
  localparam int MIN = 600;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        fast_mode;
  logic        irq;
  logic [1:0]  sense_lvl = 2'h1;
  logic [2:0]  prog = 3'h7;
  logic [1:0]  temp_lvl = 2'h1;
  logic        slope = 1'b0;
  logic        supply_low = 1'b0;
  logic [31:0] rd;
  logic [7:0]  lfsr = 8'h46;
  int          fail_count = 0;
  int          cmp_count = 0;
  cmc_pkg::cmc_comp_t comp_raw;
  always #20 hclk = ~hclk;
  cmc_pack_model cmc_pack_model_inst (.sense_lvl(sense_lvl), .prog(prog), .temp_lvl(temp_lvl),
    .slope(slope), .supply_low(supply_low), .comp_raw(comp_raw));
  cmc_top #(.SEC_CYCLES(10), .HOLDOFF_S(2)) cmc_top_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .comp_raw(comp_raw), .fast_mode(fast_mode), .irq(irq));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Limit in minutes, temperature mode reads all ones
  function automatic logic [31:0] lim(input logic [2:0] p);
    logic [31:0] t [8] = '{32'h1FF, 32'h47, 32'h6A, 32'h8D, 32'hB1, 32'hD4, 32'hF7, 32'h11B};
    return t[p];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Single AHB transfer; data taken before this edge's updates land
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic slope_ev();
    slope <= 1'b1;
    cyc(4);
    slope <= 1'b0;
    cyc(4);
  endtask
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    hresetn <= 1'b1;
    chk_pin(fast_mode, 1'b1);
    bus(cmc_pkg::CMC_OFF_CTRL, 1'b0, 32'h0);
    chk(rd, cmc_pkg::CMC_CTRL_RST);
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    bus(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      lfsr = nxt(lfsr);
      prog <= (i < 8) ? 3'(i) : lfsr[2:0];
      bus(cmc_pkg::CMC_OFF_MASK, 1'b1, {24'h0, lfsr});
      bus(cmc_pkg::CMC_OFF_MASK, 1'b0, 32'h0);
      chk(rd, {27'h0, lfsr[4:0]});
      cyc(6);
      bus(cmc_pkg::CMC_OFF_LIMIT, 1'b0, 32'h0);
      chk(rd, lim(prog));
      bus(cmc_pkg::CMC_OFF_STATUS, 1'b0, 32'h0);
      chk({31'h0, rd[5]}, {31'h0, prog == 3'h0});
    end
    $display("done: registers and decode");
    prog <= 3'h7;
    sense_lvl <= 2'h0;
    cyc(6);
    chk_pin(fast_mode, 1'b0);
    sense_lvl <= 2'h2;
    cyc(6);
    chk_pin(fast_mode, 1'b0);
    sense_lvl <= 2'h1;
    cyc(6);
    chk_pin(fast_mode, 1'b1);
    bus(cmc_pkg::CMC_OFF_IRQ, 1'b0, 32'h0);
    chk(rd, 32'h11);
    supply_low <= 1'b1;
    cyc(6);
    chk_pin(fast_mode, 1'b0);
    supply_low <= 1'b0;
    cyc(6);
    chk_pin(fast_mode, 1'b1);
    $display("done: window and supply");
    bus(cmc_pkg::CMC_OFF_MASK, 1'b1, 32'h4);
    prog <= 3'h0;
    temp_lvl <= 2'h0;
    cyc(6);
    chk_pin(fast_mode, 1'b0);
    temp_lvl <= 2'h1;
    cyc(6);
    chk_pin(fast_mode, 1'b1);
    temp_lvl <= 2'h2;
    cyc(6);
    chk_pin(irq, 1'b1);
    temp_lvl <= 2'h1;
    cyc(6);
    chk_pin(fast_mode, 1'b0);
    bus(cmc_pkg::CMC_OFF_IRQ, 1'b1, 32'h1F);
    cyc(1);
    chk_pin(irq, 1'b0);
    sense_lvl <= 2'h0;
    cyc(6);
    sense_lvl <= 2'h1;
    cyc(6);
    chk_pin(fast_mode, 1'b1);
    $display("done: temperature");
    prog <= 3'h7;
    cyc(30);
    slope_ev();
    sense_lvl <= 2'h0;
    cyc(6);
    sense_lvl <= 2'h1;
    cyc(40);
    slope_ev();
    chk_pin(fast_mode, 1'b1);
    slope_ev();
    cyc(20);
    chk_pin(fast_mode, 1'b0);
    bus(cmc_pkg::CMC_OFF_STATUS, 1'b0, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    bus(cmc_pkg::CMC_OFF_IRQ, 1'b0, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    $display("done: full charge");
    prog <= 3'h1;
    sense_lvl <= 2'h0;
    cyc(6);
    sense_lvl <= 2'h1;
    cyc(6);
    chk_pin(fast_mode, 1'b1);
    // Slope detection switched off: two events must not latch trickle
    bus(cmc_pkg::CMC_OFF_CTRL, 1'b1, 32'h1);
    slope_ev();
    slope_ev();
    cyc(12);
    chk_pin(fast_mode, 1'b1);
    cyc(72 * MIN - 76);
    chk_pin(fast_mode, 1'b1);
    cyc(80);
    chk_pin(fast_mode, 1'b0);
    bus(cmc_pkg::CMC_OFF_TIMER, 1'b0, 32'h0);
    chk(rd, lim(3'h1) + 32'h1);
    bus(cmc_pkg::CMC_OFF_IRQ, 1'b0, 32'h0);
    chk({31'h0, rd[3]}, 32'h1);
    $display("done: backup timer");
    finish_test();
  end
  initial
  begin
    cyc(60000);
    fail_count++;
    finish_test();
  end
endmodule
bind cmc_top cmc_monitor cmc_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .comp_raw(comp_raw), .fast_mode(fast_mode));
